/* File: core/multi_queue_flow_control.v */
// Multi-queue FIFO core with bus matching, packet status and flag status busses
//
// The register offsets and the plain strobed port are this design's own decisions.
`default_nettype none
`include "multi_queue_flow_control_map.vh"

// Functional notes
// - Write port word goes to selected queue
// - Read port word comes from selected queue
// - Write and read paths run independently
// - Full for write queue, empty for read
// - Per-queue programmable almost-full/almost-empty
// - Two 8-bit almost flag status busses
// - Up to eight queues: one bit each
// - Above eight queues: polled or direct words
// - Ports independently 9, 18 or 36 wide
// - Packing and unpacking is little-endian
// - Packet ready when complete packet queued
// - Packets found from start/end demarcation bits
// - One to 32 queues, independent depths
// - Configuration loaded over serial port
// - Unprogrammed device uses default configuration
// - Setup inputs latched at reset release
// - Writes ignored while selected queue full
// - No read from empty queue
// - Polled bus advances every clock edge
// - Direct mode: user selects status word
module multi_queue_flow_control #(
   parameter MAXQ       = 32,
   parameter QSEL_W     = 5,
   parameter BLK_W      = 7,
   parameter BLK_SH     = 8,
   parameter NUM_BLOCKS = 64
) (
   input  wire                  clk,
   input  wire                  reset,
   input  wire                  setup_packet_mode,
   input  wire                  setup_serial_prog,
   input  wire                  setup_polled_mode,
   input  wire                  setup_expansion_master,
   input  wire [1:0]            setup_write_width,
   input  wire [1:0]            setup_read_width,
   input  wire                  ser_enable,
   input  wire                  ser_data,
   input  wire [QSEL_W-1:0]     write_queue_select,
   input  wire                  write_enable,
   input  wire [35:0]           write_data,
   input  wire [1:0]            af_word_select,
   input  wire [QSEL_W-1:0]     read_queue_select,
   input  wire                  read_enable,
   input  wire [1:0]            ae_word_select,
   output reg  [35:0]           read_data_q,
   output reg                   read_valid_q,
   output reg                   write_full_flag_q,
   output reg                   read_empty_flag_q,
   output reg                   almost_full_flag_q,
   output reg                   almost_empty_flag_q,
   output reg                   packet_ready_flag_q,
   output reg  [7:0]            af_bus_q,
   output reg  [7:0]            ae_bus_q,
   output reg  [1:0]            af_bus_word_q,
   output reg  [1:0]            ae_bus_word_q,
   output reg                   expansion_master_q
);

   localparam CNT_W  = BLK_W + BLK_SH;
   localparam ADDR_W = CNT_W - 1;
   localparam MEM_WORDS = NUM_BLOCKS << BLK_SH;

   // ********************************************************************
   // Helpers
   // ********************************************************************
   function [1:0] last_lane;
      input [1:0] mode;
      begin
         case (mode)
            `MQ_WIDTH_18: last_lane = 2'h1;
            `MQ_WIDTH_9:  last_lane = 2'h3;
            default:      last_lane = 2'h0;
         endcase
      end
   endfunction

   function [CNT_W-1:0] words_of;
      input [BLK_W-1:0] blocks;
      begin
         words_of = {blocks, {BLK_SH{1'b0}}};
      end
   endfunction

   function [BLK_W-1:0] def_base;
      input integer q;
      reg [31:0] t;
      begin
         t = q * `MQ_DEF_BLOCKS;
         def_base = t[BLK_W-1:0];
      end
   endfunction

   // ********************************************************************
   // State
   // ********************************************************************
   reg [35:0]        mem [0:MEM_WORDS-1];
   reg [BLK_W-1:0]   base_q  [0:MAXQ-1];
   reg [BLK_W-1:0]   size_q  [0:MAXQ-1];
   reg [CNT_W-1:0]   ae_thr_q[0:MAXQ-1];
   reg [CNT_W-1:0]   af_thr_q[0:MAXQ-1];
   reg [CNT_W-1:0]   wr_off_q[0:MAXQ-1];
   reg [CNT_W-1:0]   rd_off_q[0:MAXQ-1];
   reg [CNT_W-1:0]   cnt_q   [0:MAXQ-1];
   reg [CNT_W-1:0]   pkt_q   [0:MAXQ-1];
   reg [MAXQ-1:0]    sop_seen_q;

   reg               reset_q;
   reg               packet_mode_q;
   reg               serial_prog_q;
   reg               polled_mode_q;
   reg [1:0]         wwidth_q;
   reg [1:0]         rwidth_q;
   reg [5:0]         nq_q;
   reg [BLK_W-1:0]   alloc_q;
   reg [47:0]        shift_q;
   reg [5:0]         bitcnt_q;
   reg               ser_en_q;
   reg [35:0]        wpack_q;
   reg [1:0]         wlane_q;
   reg [1:0]         rlane_q;
   reg [QSEL_W-1:0]  wsel_q;
   reg [QSEL_W-1:0]  rsel_q;
   reg [1:0]         af_poll_q;
   reg [1:0]         ae_poll_q;

   reg [MAXQ-1:0]    full_v;
   reg [MAXQ-1:0]    empty_v;
   reg [MAXQ-1:0]    af_v;
   reg [MAXQ-1:0]    ae_v;
   reg [35:0]        wword;
   reg [35:0]        rlane_data;
   integer           i;

   wire              wsel_ok  = {1'b0, write_queue_select} < nq_q;
   wire              rsel_ok  = {1'b0, read_queue_select} < nq_q;
   wire [1:0]        wlane    = (write_queue_select != wsel_q) ? 2'h0 : wlane_q;
   wire [1:0]        rlane    = (read_queue_select != rsel_q) ? 2'h0 : rlane_q;
   wire              do_write = write_enable & wsel_ok & ~full_v[write_queue_select];
   wire              do_read  = read_enable & rsel_ok & ~empty_v[read_queue_select];
   wire              wcommit  = do_write & (wlane == last_lane(wwidth_q));
   wire              rpop     = do_read & (rlane == last_lane(rwidth_q));
   wire [CNT_W-1:0]  waddr    = words_of(base_q[write_queue_select]) + wr_off_q[write_queue_select];
   wire [CNT_W-1:0]  raddr    = words_of(base_q[read_queue_select]) + rd_off_q[read_queue_select];
   wire [35:0]       rword    = mem[raddr[ADDR_W-1:0]];
   wire              frame_end = ser_en_q & ~ser_enable & serial_prog_q & (bitcnt_q == `MQ_FRAME_BITS);
   wire [QSEL_W-1:0] fq       = shift_q[`MQ_FR_Q_HI:`MQ_FR_Q_LO];
   wire [BLK_W-1:0]  fblk     = shift_q[`MQ_FR_BLK_HI:`MQ_FR_BLK_LO];
   wire [5:0]        fnq      = shift_q[`MQ_FR_NQ_HI:`MQ_FR_NQ_LO];
   wire [1:0]        nwords_m1 = (nq_q > 6'h18) ? 2'h3 : (nq_q > 6'h10) ? 2'h2 : 2'h1;
   wire [1:0]        af_word  = polled_mode_q ? af_poll_q : af_word_select;
   wire [1:0]        ae_word  = polled_mode_q ? ae_poll_q : ae_word_select;

   // ********************************************************************
   // Per-queue status
   // ********************************************************************
   always @*
   begin
      for (i = 0; i < MAXQ; i = i + 1)
      begin
         full_v[i]  = (cnt_q[i] == words_of(size_q[i]));
         empty_v[i] = (cnt_q[i] == {CNT_W{1'b0}});
         af_v[i]    = (i < nq_q) && ({1'b0, cnt_q[i]} + {1'b0, af_thr_q[i]} >= {1'b0, words_of(size_q[i])});
         ae_v[i]    = (i < nq_q) && (cnt_q[i] <= ae_thr_q[i]);
      end
   end

   // ********************************************************************
   // Bus matching: pack on write, unpack on read, low lane first
   // ********************************************************************
   always @*
   begin
      wword = wpack_q;
      case (wwidth_q)
         `MQ_WIDTH_18: wword[wlane[0]*18 +: 18] = write_data[17:0];
         `MQ_WIDTH_9:  wword[wlane*9 +: 9]      = write_data[8:0];
         default:      wword                    = write_data;
      endcase
   end

   always @*
   begin
      case (rwidth_q)
         `MQ_WIDTH_18: rlane_data = {18'h00000, rword[rlane[0]*18 +: 18]};
         `MQ_WIDTH_9:  rlane_data = {27'h0000000, rword[rlane*9 +: 9]};
         default:      rlane_data = rword;
      endcase
   end

   always @(posedge clk)
   begin
      if (wcommit)
         mem[waddr[ADDR_W-1:0]] <= wword;
   end

   // ********************************************************************
   // Setup latch, serial programming, lane tracking
   // ********************************************************************
   always @(posedge clk)
   begin
      reset_q <= reset;
      if (reset)
      begin
         packet_mode_q      <= 1'b0;
         serial_prog_q      <= 1'b0;
         polled_mode_q      <= 1'b0;
         wwidth_q           <= `MQ_WIDTH_36;
         rwidth_q           <= `MQ_WIDTH_36;
         expansion_master_q <= 1'b0;
         shift_q            <= 48'h000000000000;
         bitcnt_q           <= 6'h00;
         ser_en_q           <= 1'b0;
         wpack_q            <= 36'h000000000;
         wlane_q            <= 2'h0;
         rlane_q            <= 2'h0;
         wsel_q             <= {QSEL_W{1'b0}};
         rsel_q             <= {QSEL_W{1'b0}};
         af_poll_q          <= 2'h0;
         ae_poll_q          <= 2'h0;
      end
      else
      begin
         if (reset_q)
         begin
            packet_mode_q      <= setup_packet_mode;
            serial_prog_q      <= setup_serial_prog;
            polled_mode_q      <= setup_polled_mode;
            wwidth_q           <= setup_write_width;
            rwidth_q           <= setup_read_width;
            expansion_master_q <= setup_expansion_master;
         end
         ser_en_q <= ser_enable;
         if (ser_enable)
         begin
            shift_q  <= {shift_q[46:0], ser_data};
            bitcnt_q <= (bitcnt_q == `MQ_FRAME_BITS) ? bitcnt_q : bitcnt_q + 6'h01;
         end
         else
            bitcnt_q <= 6'h00;
         wsel_q <= write_queue_select;
         rsel_q <= read_queue_select;
         if (do_write)
         begin
            wpack_q <= wword;
            wlane_q <= wcommit ? 2'h0 : wlane + 2'h1;
         end
         else
            wlane_q <= wlane;
         if (do_read)
            rlane_q <= rpop ? 2'h0 : rlane + 2'h1;
         else
            rlane_q <= rlane;
         af_poll_q <= (af_poll_q >= nwords_m1) ? 2'h0 : af_poll_q + 2'h1;
         ae_poll_q <= (ae_poll_q >= nwords_m1) ? 2'h0 : ae_poll_q + 2'h1;
      end
   end

   // ********************************************************************
   // Queue table, levels and packet counts
   // ********************************************************************
   always @(posedge clk)
   begin
      if (reset)
      begin
         nq_q       <= `MQ_DEF_NQ;
         alloc_q    <= {BLK_W{1'b0}};
         sop_seen_q <= {MAXQ{1'b0}};
         for (i = 0; i < MAXQ; i = i + 1)
         begin
            base_q[i]   <= def_base(i);
            size_q[i]   <= (i < `MQ_DEF_NQ) ? `MQ_DEF_BLOCKS : {BLK_W{1'b0}};
            ae_thr_q[i] <= `MQ_DEF_AE_THR;
            af_thr_q[i] <= `MQ_DEF_AF_THR;
            wr_off_q[i] <= {CNT_W{1'b0}};
            rd_off_q[i] <= {CNT_W{1'b0}};
            cnt_q[i]    <= {CNT_W{1'b0}};
            pkt_q[i]    <= {CNT_W{1'b0}};
         end
      end
      else if (frame_end)
      begin
         nq_q               <= (fnq == 6'h00) ? 6'h01 : (fnq > 6'h20) ? 6'h20 : fnq;
         base_q[fq]         <= alloc_q;
         size_q[fq]         <= fblk;
         ae_thr_q[fq]       <= shift_q[`MQ_FR_AE_HI:`MQ_FR_AE_LO];
         af_thr_q[fq]       <= shift_q[`MQ_FR_AF_HI:`MQ_FR_AF_LO];
         alloc_q            <= alloc_q + fblk;
         wr_off_q[fq]       <= {CNT_W{1'b0}};
         rd_off_q[fq]       <= {CNT_W{1'b0}};
         cnt_q[fq]          <= {CNT_W{1'b0}};
         pkt_q[fq]          <= {CNT_W{1'b0}};
         sop_seen_q[fq]     <= 1'b0;
      end
      else
      begin
         for (i = 0; i < MAXQ; i = i + 1)
         begin
            if (wcommit && write_queue_select == i[QSEL_W-1:0])
            begin
               wr_off_q[i] <= (wr_off_q[i] + 1'b1 == words_of(size_q[i])) ? {CNT_W{1'b0}}
                                                                          : wr_off_q[i] + 1'b1;
               if (wword[`MQ_EOP_BIT])
                  sop_seen_q[i] <= 1'b0;
               else if (wword[`MQ_SOP_BIT])
                  sop_seen_q[i] <= 1'b1;
            end
            if (rpop && read_queue_select == i[QSEL_W-1:0])
               rd_off_q[i] <= (rd_off_q[i] + 1'b1 == words_of(size_q[i])) ? {CNT_W{1'b0}}
                                                                          : rd_off_q[i] + 1'b1;
            // Same-queue write and pop in one cycle leaves the level unchanged
            cnt_q[i] <= cnt_q[i]
                        + {{(CNT_W-1){1'b0}}, (wcommit && write_queue_select == i[QSEL_W-1:0])}
                        - {{(CNT_W-1){1'b0}}, (rpop && read_queue_select == i[QSEL_W-1:0])};
            pkt_q[i] <= pkt_q[i]
                        + {{(CNT_W-1){1'b0}}, (wcommit && write_queue_select == i[QSEL_W-1:0]
                           && wword[`MQ_EOP_BIT] && (sop_seen_q[i] || wword[`MQ_SOP_BIT]))}
                        - {{(CNT_W-1){1'b0}}, (rpop && read_queue_select == i[QSEL_W-1:0]
                           && rword[`MQ_EOP_BIT] && pkt_q[i] != {CNT_W{1'b0}})};
         end
      end
   end

   // ********************************************************************
   // Output registers
   // ********************************************************************
   always @(posedge clk)
   begin
      if (reset)
      begin
         read_data_q         <= 36'h000000000;
         read_valid_q        <= 1'b0;
         write_full_flag_q   <= 1'b0;
         read_empty_flag_q   <= 1'b1;
         almost_full_flag_q  <= 1'b0;
         almost_empty_flag_q <= 1'b1;
         packet_ready_flag_q <= 1'b0;
         af_bus_q            <= 8'h00;
         ae_bus_q            <= 8'hFF;
         af_bus_word_q       <= 2'h0;
         ae_bus_word_q       <= 2'h0;
      end
      else
      begin
         if (do_read)
            read_data_q <= rlane_data;
         read_valid_q        <= do_read;
         write_full_flag_q   <= ~wsel_ok | full_v[write_queue_select];
         read_empty_flag_q   <= ~rsel_ok | empty_v[read_queue_select];
         almost_full_flag_q  <= ~wsel_ok | af_v[write_queue_select];
         almost_empty_flag_q <= ~rsel_ok | ae_v[read_queue_select];
         packet_ready_flag_q <= packet_mode_q & rsel_ok
                                & (pkt_q[read_queue_select] != {CNT_W{1'b0}});
         if (nq_q <= 6'h08)
         begin
            af_bus_q      <= af_v[7:0];
            ae_bus_q      <= ae_v[7:0];
            af_bus_word_q <= 2'h0;
            ae_bus_word_q <= 2'h0;
         end
         else
         begin
            af_bus_q      <= af_v[af_word*`MQ_FLAG_BUS_W +: `MQ_FLAG_BUS_W];
            ae_bus_q      <= ae_v[ae_word*`MQ_FLAG_BUS_W +: `MQ_FLAG_BUS_W];
            af_bus_word_q <= af_word;
            ae_bus_word_q <= ae_word;
         end
      end
   end

endmodule // multi_queue_flow_control
`default_nettype wire

/* File: core/multi_queue_flow_control_map.vh */
// Constants for the multi-queue flow-control core: encodings, field positions, reset values
`ifndef MULTI_QUEUE_FLOW_CONTROL_MAP_VH
`define MULTI_QUEUE_FLOW_CONTROL_MAP_VH

// ***********************************************************************
// Port width encodings (bus matching)
// ***********************************************************************
`define MQ_WIDTH_36      2'h0
`define MQ_WIDTH_18      2'h1
`define MQ_WIDTH_9       2'h2

// ***********************************************************************
// Packet demarcation bits inside a stored 36-bit word
// ***********************************************************************
`define MQ_SOP_BIT       8
`define MQ_EOP_BIT       17

// ***********************************************************************
// Serial configuration frame, shifted in MSB first
// ***********************************************************************
`define MQ_FRAME_BITS    6'h30
`define MQ_FR_NQ_HI      47
`define MQ_FR_NQ_LO      42
`define MQ_FR_Q_HI       41
`define MQ_FR_Q_LO       37
`define MQ_FR_BLK_HI     36
`define MQ_FR_BLK_LO     30
`define MQ_FR_AE_HI      29
`define MQ_FR_AE_LO      15
`define MQ_FR_AF_HI      14
`define MQ_FR_AF_LO      0

// ***********************************************************************
// Default configuration
// ***********************************************************************
`define MQ_DEF_NQ        6'h08
`define MQ_DEF_BLOCKS    7'h08
`define MQ_DEF_AE_THR    15'h007F
`define MQ_DEF_AF_THR    15'h007F
`define MQ_FLAG_BUS_W    8

`endif

/* File: test/multi_queue_flow_control_checker.sv */
// Port checker for the multi-queue core
`default_nettype none
module multi_queue_flow_control_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        setup_expansion_master,
   input wire logic        write_enable,
   input wire logic        read_enable,
   input wire logic [4:0]  read_queue_select,
   input wire logic [35:0] read_data_q,
   input wire logic        read_valid_q,
   input wire logic        write_full_flag_q,
   input wire logic        read_empty_flag_q,
   input wire logic        almost_full_flag_q,
   input wire logic        almost_empty_flag_q,
   input wire logic        packet_ready_flag_q,
   input wire logic [7:0]  af_bus_q,
   input wire logic [7:0]  ae_bus_q,
   input wire logic        expansion_master_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ***********************************************************************
   // Sequences and properties
   // ***********************************************************************
   sequence s_quiet;
      !read_valid_q && !packet_ready_flag_q;
   endsequence
   sequence s_clear_flags;
      read_empty_flag_q && almost_empty_flag_q && !write_full_flag_q && !almost_full_flag_q
         && af_bus_q == 8'h00 && ae_bus_q == 8'hFF;
   endsequence
   property p_valid_cause; read_valid_q |-> $past(read_enable); endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("read valid without read strobe");
   property p_data_hold; !read_valid_q |-> $stable(read_data_q); endproperty
   a_data_hold: assert property (p_data_hold) else $error("read data moved without a read");
   property p_reset_flags; $fell(reset) |-> s_clear_flags; endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("flags wrong after reset");
   property p_strap; $fell(reset) |=> expansion_master_q == $past(setup_expansion_master); endproperty
   a_strap: assert property (p_strap) else $error("expansion role not latched");
   property p_quiet; $fell(reset) |-> s_quiet [*2]; endproperty
   a_quiet: assert property (p_quiet) else $error("output activity right after reset");
   property p_empty_read;
      read_enable && read_empty_flag_q && !write_enable && !$past(write_enable)
         && read_queue_select == $past(read_queue_select) |=> !read_valid_q;
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("data delivered from empty queue");
   property p_empty_ae; read_empty_flag_q |-> almost_empty_flag_q; endproperty
   a_empty_ae: assert property (p_empty_ae) else $error("empty queue not almost empty");
   property p_full_af; write_full_flag_q |-> almost_full_flag_q; endproperty
   a_full_af: assert property (p_full_af) else $error("full queue not almost full");
endmodule // multi_queue_flow_control_checker

bind multi_queue_flow_control multi_queue_flow_control_checker i_checker (.clk, .reset, .setup_expansion_master,
   .write_enable, .read_enable, .read_queue_select, .read_data_q, .read_valid_q, .write_full_flag_q,
   .read_empty_flag_q, .almost_full_flag_q, .almost_empty_flag_q, .packet_ready_flag_q, .af_bus_q, .ae_bus_q,
   .expansion_master_q);
`default_nettype wire

/* File: test/ser_prog_model.sv */
// Serial configuration controller on the far side of the core
`default_nettype none
module ser_prog_model (
   input wire logic clk,
   output var logic ser_enable,
   output var logic ser_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      ser_enable = 1'b0;
      ser_data = 1'b0;
   end
   // Called only after master reset has completed
   task automatic send(input logic [47:0] f);
      for (int i = 47; i >= 0; i--)
      begin
         @(posedge clk);
         {ser_enable, ser_data} <= {1'b1, f[i]};
      end
      @(posedge clk);
      // Released line shows the inverse of the last bit
      {ser_enable, ser_data} <= {1'b0, ~f[0]};
   endtask
endmodule // ser_prog_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the multi-queue core
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, s_pkt, s_ser, s_poll, s_mst, we, re;
   logic [1:0]  s_ww, s_rw, af_ws, ae_ws;
   logic [4:0]  wq, rq;
   logic [35:0] wd;
   wire logic   ser_en, ser_d, rvalid, wfull, rempty, afl, ael, prdy, emst;
   wire logic [35:0] rdata;
   wire logic [7:0]  afb, aeb;
   wire logic [1:0]  afw, aew;
   int          n_mismatch = 0, total_checks = 0, cycles = 0, cap, nq, wcnt;
   integer      seed = 32'h5239CFA1;
   logic [35:0] mq [8][$];
   logic [35:0] got [$], exp [$];
   logic        mdl;
   logic [1:0]  a0;
   logic [35:0] w;
   multi_queue_flow_control i_multi_queue_flow_control (.clk(clk), .reset(reset), .setup_packet_mode(s_pkt),
      .setup_serial_prog(s_ser), .setup_polled_mode(s_poll), .setup_expansion_master(s_mst),
      .setup_write_width(s_ww), .setup_read_width(s_rw), .ser_enable(ser_en), .ser_data(ser_d),
      .write_queue_select(wq), .write_enable(we), .write_data(wd), .af_word_select(af_ws),
      .read_queue_select(rq), .read_enable(re), .ae_word_select(ae_ws), .read_data_q(rdata),
      .read_valid_q(rvalid), .write_full_flag_q(wfull), .read_empty_flag_q(rempty),
      .almost_full_flag_q(afl), .almost_empty_flag_q(ael), .packet_ready_flag_q(prdy), .af_bus_q(afb),
      .ae_bus_q(aeb), .af_bus_word_q(afw), .ae_bus_word_q(aew), .expansion_master_q(emst));
   ser_prog_model i_ser_prog_model (.clk(clk), .ser_enable(ser_en), .ser_data(ser_d));
   // ***********************************************************************
   // Helpers
   // ***********************************************************************
   function automatic logic [35:0] rnd();
      logic [63:0] t;
      t = {$random(seed), $random(seed)};
      return t[35:0];
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk_val(input logic [35:0] a, input logic [35:0] b);
      total_checks++;
      if (a !== b)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, a, b);
      end
   endtask
   task automatic chk_stream(input logic [35:0] m);
      chk_val(36'(got.size()), 36'(exp.size()));
      for (int i = 0; i < exp.size() && i < got.size(); i++)
         chk_val(got[i] & m, exp[i]);
      got.delete();
      exp.delete();
   endtask
   // One port cycle; full is judged before the pop, and the pop sees only earlier writes
   task automatic cyc(input logic w_en, input logic [4:0] q, input logic [35:0] d, input logic r,
                      input logic [4:0] p);
      logic pw;
      @(posedge clk);
      pw = mdl && w_en && q < nq && mq[q].size() < cap;
      {we, wq, wd, re, rq} <= {w_en, q, d, r, p};
      if (mdl && r && p < nq && mq[p].size() > 0)
         exp.push_back(mq[p].pop_front());
      if (pw)
         mq[q].push_back(d);
   endtask
   task automatic wait3(input logic [4:0] q, input logic [4:0] p);
      repeat (3) cyc(1'b0, q, 36'h0, 1'b0, p);
   endtask
   task automatic drain();
      for (int q = 0; q < nq; q++)
         while (mq[q].size() > 0)
            cyc(1'b0, 5'(q), 36'h0, 1'b1, 5'(q));
      wait3(5'h00, 5'h00);
   endtask
   task automatic fill(input int n);
      repeat (n)
      begin
         cyc(1'b1, 5'h03, 36'(wcnt), 1'b0, 5'h03);
         wcnt++;
      end
      wait3(5'h03, 5'h03);
   endtask
   task automatic do_reset(input logic pkt, input logic ser, input logic poll, input logic [1:0] ww,
                           input logic [1:0] rw);
      logic m;
      m = $random(seed);
      @(posedge clk);
      {reset, s_pkt, s_ser, s_poll, s_ww, s_rw, s_mst, we, re} <= {1'b1, pkt, ser, poll, ww, rw, m, 2'b00};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      {mdl, nq, cap} = {1'b1, 32'd8, 32'd2048};
      for (int q = 0; q < 8; q++)
         mq[q].delete();
      repeat (2) @(posedge clk);
      chk_val(36'(emst), 36'(m));
   endtask
   // ***********************************************************************
   // Clock, timeout and read monitor
   // ***********************************************************************
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (rvalid === 1'b1)
         got.push_back(rdata);
      if (cycles == 40000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   // ***********************************************************************
   // Scenarios
   // ***********************************************************************
   initial
   begin
      {s_pkt, s_ser, s_poll, s_mst, we, re, s_ww, s_rw, af_ws, ae_ws, wq, rq, wd} = '0;
      reset = 1'b1;
      {mdl, nq, cap, wcnt} = {1'b1, 32'd8, 32'd2048, 32'd0};
      do_reset(1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
      wait3(5'h00, 5'h00);
      chk_val(36'(rempty), 36'h1);
      repeat (400) cyc($random(seed), 5'(rnd() & 36'h7), rnd(), $random(seed), 5'(rnd() & 36'h7));
      drain();
      chk_stream(36'hFFFFFFFFF);
      $display("test random traffic done");
      fill(127);
      chk_val(36'(ael), 36'h1);
      fill(1);
      chk_val(36'({ael, aeb[3], aeb[2]}), 36'h1);
      fill(1792);
      chk_val(36'(afl), 36'h0);
      fill(1);
      chk_val(36'({afl, afb[3], afb[2]}), 36'h6);
      fill(128);
      chk_val(36'(wfull), 36'h1);
      drain();
      chk_stream(36'hFFFFFFFFF);
      $display("test fill and flags done");
      do_reset(1'b1, 1'b0, 1'b0, 2'h0, 2'h0);
      cyc(1'b1, 5'h00, 36'h000000100, 1'b0, 5'h00);
      wait3(5'h00, 5'h00);
      chk_val(36'(prdy), 36'h0);
      cyc(1'b1, 5'h00, 36'h000020000, 1'b0, 5'h00);
      wait3(5'h00, 5'h00);
      chk_val(36'(prdy), 36'h1);
      drain();
      chk_val(36'(prdy), 36'h0);
      chk_stream(36'hFFFFFFFFF);
      $display("test packet done");
      do_reset(1'b0, 1'b0, 1'b0, 2'h1, 2'h2);
      mdl = 1'b0;
      repeat (2)
      begin
         w = rnd();
         cyc(1'b1, 5'h00, {18'h0, w[17:0]}, 1'b0, 5'h00);
         cyc(1'b1, 5'h00, {18'h0, w[35:18]}, 1'b0, 5'h00);
         for (int i = 0; i < 4; i++)
            exp.push_back({27'h0, w[i*9 +: 9]});
      end
      repeat (8) cyc(1'b0, 5'h00, 36'h0, 1'b1, 5'h00);
      wait3(5'h00, 5'h00);
      chk_stream(36'h0000001FF);
      $display("test bus matching done");
      do_reset(1'b0, 1'b1, 1'b1, 2'h0, 2'h0);
      {nq, cap} = {32'd1, 32'd256};
      i_ser_prog_model.send({6'h10, 5'h00, 7'h01, 15'h0000, 15'h0000});
      repeat (3) @(posedge clk);
      a0 = afw;
      @(posedge clk);
      chk_val(36'({afw, aew}), 36'({a0 ^ 2'h1, a0 ^ 2'h1}));
      cyc(1'b1, 5'h10, 36'h5, 1'b0, 5'h00);
      wait3(5'h10, 5'h00);
      chk_val(36'(wfull), 36'h1);
      repeat (257) cyc(1'b1, 5'h00, rnd(), 1'b0, 5'h00);
      wait3(5'h00, 5'h00);
      chk_val(36'(wfull), 36'h1);
      drain();
      chk_stream(36'hFFFFFFFFF);
      $display("test serial setup done");
      do_reset(1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
      i_ser_prog_model.send({6'h10, 5'h00, 7'h01, 15'h0000, 15'h0000});
      @(posedge clk);
      {af_ws, ae_ws} <= 4'h5;
      wait3(5'h00, 5'h00);
      chk_val(36'({afw, aew, afb, aeb}), 36'h5FFFF);
      @(posedge clk);
      {af_ws, ae_ws} <= 4'h0;
      wait3(5'h00, 5'h00);
      chk_val(36'({afw, afb}), 36'h000);
      $display("test direct flag words done");
      close_out();
   end
endmodule // tb
`default_nettype wire
